//--- shared/rpm_defs.vh
/*
 * Constants for the repeater partition and management port block.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef RPM_DEFS_VH
`define RPM_DEFS_VH

// ****************************************************************
// Clock and bit time
// ****************************************************************
`define RPM_CLK_MHZ         40
`define RPM_BIT_MHZ         10
`define RPM_BIT_DIV         4'h4
`define RPM_BIT_DIV_W       4

// ****************************************************************
// Repeater limits; lengths in bit times
// ****************************************************************
`define RPM_NPORTS          14
`define RPM_FRAG_MIN        12'h060
`define RPM_SQE_MAX         12'h800
`define RPM_COL_RUN         6'h20
`define RPM_RECON_LEN       12'h200
`define RPM_CNT_W           12

// ****************************************************************
// Control byte layout
// ****************************************************************
`define RPM_CB_TOP_BANK     3'h0
`define RPM_CB_TOP_REG      3'h7
`define RPM_FIELD_W         5

// ****************************************************************
// Bank numbers
// ****************************************************************
`define RPM_BANK_REPEATER   5'h00
`define RPM_BANK_INT_FLAGS  5'h01
`define RPM_BANK_INT_EN     5'h02
`define RPM_BANK_PORT_CTL   5'h03
`define RPM_BANK_PORT_STAT  5'h04
`define RPM_BANK_RMON       5'h05
`define RPM_BANK_REPORT     5'h07
`define RPM_BANK_ATTR_LO    5'h10
`define RPM_BANK_ATTR_HI    5'h1E

// ****************************************************************
// Register numbers and port access constants used by this block
// ****************************************************************
`define RPM_REG_PART_CHG    5'h00
`define RPM_REG_ALT_RECON   5'h00
`define RPM_REG_PART_STAT   5'h00
`define RPM_REG_BYTES       2'h2
`define RPM_RST_WORD        16'h0000
`define RPM_RDY_WAIT        2'h2

`endif

//--- design/rpm_top.v
/*
 * Repeater partition and management port block: fragment extension,
 * per-port auto partition and reconnection, packet report tagging, and
 * an 8-bit control/data multiplexed processor port with bank select.
 * Assumes all inputs but nrst synchronous to core_clk; the bench resolves the
 * open-drain and data pins from the enable outputs.
 */
`timescale 1ns/1ps
`include "rpm_defs.vh"

module rpm_top (
  input  wire        core_clk,     // 40 MHz clock
  input  wire        nrst,         // Async reset, active low
  input  wire [13:0] port_en,      // Port enables
  input  wire [13:0] rx_act,       // Receive activity per port
  input  wire [13:0] sqe,          // Collision presence per port
  input  wire [13:0] tx_col,       // Collision during transmit
  input  wire        tx_act,       // Repeater transmitting
  input  wire [3:0]  rx_port,      // Port currently received
  input  wire        pkt_end,      // Pulse at end of packet
  input  wire        cs_n,         // Chip select
  input  wire        rd_n,         // Read strobe
  input  wire        wr_n,         // Write strobe
  input  wire        cd_sel,       // Control/data select
  input  wire [7:0]  d_in,         // Data bus in
  output reg  [7:0]  d_out,        // Data bus out
  output wire        d_oe_n,       // Data bus enable, low drives
  output wire        rdy_oe_n,     // Ready pull-low enable
  output wire        int_oe_n,     // Interrupt pull-low enable
  output wire        jam_out,      // Jam pad active
  output wire [13:0] tx_en,        // Transmit enable per port
  output wire [13:0] rx_ok,        // Receive accepted per port
  output reg  [13:0] part_q,       // Partition state per port
  output reg         rep_valid,    // Report byte valid pulse
  output reg  [7:0]  rep_byte      // Report byte
);

  // ****************************************************************
  // Reset synchroniser
  // ****************************************************************
  reg rs1_q, rs2_q;
  wire rst_n = rs2_q;

  // Two-stage release of the reset
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end

  // ****************************************************************
  // Bit time enable
  // ****************************************************************
  reg [`RPM_BIT_DIV_W-1:0] div_q;
  wire bit_en = (div_q == `RPM_BIT_DIV - 4'h1);

  // Divider for one bit time
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      div_q <= {`RPM_BIT_DIV_W{1'b0}};
    else if (bit_en)
      div_q <= {`RPM_BIT_DIV_W{1'b0}};
    else
      div_q <= div_q + 4'h1;
  end

  // ****************************************************************
  // Fragment extension
  // ****************************************************************
  reg [`RPM_CNT_W-1:0] len_q;
  reg tx_d1_q, jam_q;

  // Count transmitted bits and pad short ones with jam
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      len_q   <= {`RPM_CNT_W{1'b0}};
      tx_d1_q <= 1'b0;
      jam_q   <= 1'b0;
    end else begin
      tx_d1_q <= tx_act;
      if (tx_act && !tx_d1_q)
        len_q <= {`RPM_CNT_W{1'b0}};
      else if (bit_en && (tx_act || jam_q) && len_q != 12'hFFF)
        len_q <= len_q + 12'h001;
      if (!tx_act && tx_d1_q && len_q < `RPM_FRAG_MIN)
        jam_q <= 1'b1;
      else if (bit_en && len_q >= `RPM_FRAG_MIN - 12'h001)
        jam_q <= 1'b0; // Ends on the 96th bit
    end
  end
  assign jam_out = jam_q;

  // ****************************************************************
  // Per-port partition machines
  // ****************************************************************
  reg [13:0] alt_q;
  assign tx_en = port_en;
  assign rx_ok = port_en & rx_act & ~part_q;

  genvar gi;
  generate
    for (gi = 0; gi < `RPM_NPORTS; gi = gi + 1) begin : g_port
      reg [`RPM_CNT_W-1:0] sqe_q, pl_q;
      reg [5:0] cr_q;
      reg clean_q, in_pkt_q, txd_q;
      wire act = tx_act | rx_act[gi];
      // Alternate scheme credits only packets sent out on the port
      wire recon_ok = alt_q[gi] ? txd_q : 1'b1;

      // Independent state for each port
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          part_q[gi] <= 1'b0;
          sqe_q      <= {`RPM_CNT_W{1'b0}};
          pl_q       <= {`RPM_CNT_W{1'b0}};
          cr_q       <= 6'h00;
          clean_q    <= 1'b0;
          in_pkt_q   <= 1'b0;
          txd_q      <= 1'b0;
        end else begin
          in_pkt_q <= act;
          // SQE duration in bit times
          if (!sqe[gi])
            sqe_q <= {`RPM_CNT_W{1'b0}};
          else if (bit_en && sqe_q != 12'hFFF)
            sqe_q <= sqe_q + 12'h001;
          // Length of packet and collision freedom
          if (act && !in_pkt_q) begin
            pl_q    <= {`RPM_CNT_W{1'b0}};
            clean_q <= 1'b1;
            txd_q   <= tx_act;
          end else if (act) begin
            if (tx_act)
              txd_q <= 1'b1;
            if (bit_en && pl_q != 12'hFFF)
              pl_q <= pl_q + 12'h001;
            if (tx_col[gi] || sqe[gi])
              clean_q <= 1'b0;
          end
          // Consecutive colliding transmit attempts
          if (!act && in_pkt_q) begin
            if (!clean_q && cr_q != `RPM_COL_RUN)
              cr_q <= cr_q + 6'h01;
            else if (clean_q)
              cr_q <= 6'h00;
          end
          if (!part_q[gi]) begin
            if (port_en[gi] && (sqe_q > `RPM_SQE_MAX))
              part_q[gi] <= 1'b1;
            else if (port_en[gi] && cr_q == `RPM_COL_RUN)
              part_q[gi] <= 1'b1;
          end else if (!act && in_pkt_q && clean_q &&
                       pl_q > `RPM_RECON_LEN &&
                       recon_ok) begin
            part_q[gi] <= 1'b0;
            cr_q       <= 6'h00;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Processor port
  // ****************************************************************
  reg [4:0]  bank_q, reg_q;
  reg [1:0]  bcnt_q, wait_q;
  reg [7:0]  lsb_q;
  reg [13:0] chg_q, ien_q;
  reg        strobe_d1_q;
  wire strobe = !cs_n && (!rd_n || !wr_n);
  wire wr_go  = strobe && !strobe_d1_q && !wr_n;
  wire rd_go  = strobe && !strobe_d1_q && !rd_n;

  // Bank decode for every register select
  function is_bank;
    input [4:0] b;
    input [4:0] want;
    begin
      is_bank = (b == want);
    end
  endfunction

  wire sel_ctl  = is_bank(bank_q, `RPM_BANK_PORT_CTL) &&
                  reg_q == `RPM_REG_ALT_RECON;
  wire sel_ien  = is_bank(bank_q, `RPM_BANK_INT_EN) &&
                  reg_q == `RPM_REG_PART_CHG;
  wire sel_chg  = is_bank(bank_q, `RPM_BANK_INT_FLAGS) &&
                  reg_q == `RPM_REG_PART_CHG;
  wire sel_stat = is_bank(bank_q, `RPM_BANK_PORT_STAT) &&
                  reg_q == `RPM_REG_PART_STAT;
  reg  [13:0] part_d1_q;
  wire [13:0] part_evt = part_q ^ part_d1_q;
  wire [15:0] wword = {d_in, lsb_q}; // LSB first

  // Register select, byte counting and writes
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_q      <= 5'h00;
      reg_q       <= 5'h00;
      bcnt_q      <= 2'h0;
      lsb_q       <= 8'h00;
      alt_q       <= 14'h0000; // Standard scheme
      ien_q       <= 14'h0000;
      chg_q       <= 14'h0000;
      part_d1_q   <= 14'h0000;
      strobe_d1_q <= 1'b0;
      wait_q      <= 2'h0;
    end else begin
      strobe_d1_q <= strobe;
      part_d1_q   <= part_q;
      wait_q <= strobe ? (wait_q != `RPM_RDY_WAIT ? wait_q + 2'h1
                                                  : wait_q) : 2'h0;
      if (wr_go && cd_sel) begin
        bcnt_q <= 2'h0;
        if (d_in[7:5] == `RPM_CB_TOP_BANK)
          bank_q <= d_in[4:0];
        else if (d_in[7:5] == `RPM_CB_TOP_REG)
          reg_q <= d_in[4:0];
      end else if ((wr_go || rd_go) && !cd_sel) begin
        if (bcnt_q == `RPM_REG_BYTES - 2'h1)
          bcnt_q <= 2'h0;
        else
          bcnt_q <= bcnt_q + 2'h1;
        if (wr_go && bcnt_q == 2'h0)
          lsb_q <= d_in;
        if (wr_go && bcnt_q == `RPM_REG_BYTES - 2'h1) begin
          if (sel_ctl)
            alt_q <= wword[13:0];
          if (sel_ien)
            ien_q <= wword[13:0];
        end
      end
      // Change flags: set wins over write-one clear
      if (wr_go && !cd_sel && sel_chg &&
          bcnt_q == `RPM_REG_BYTES - 2'h1)
        chg_q <= (chg_q & ~wword[13:0]) | part_evt;
      else
        chg_q <= chg_q | part_evt;
    end
  end

  // Read data for the selected byte
  reg [15:0] rword;
  always @* begin
    rword = `RPM_RST_WORD;
    if (cd_sel)
      rword = {8'h00, 7'h00, |(chg_q & ien_q)};
    else if (sel_ctl)
      rword = {2'h0, alt_q};
    else if (sel_ien)
      rword = {2'h0, ien_q};
    else if (sel_chg)
      rword = {2'h0, chg_q};
    else if (sel_stat)
      rword = {2'h0, part_q};
  end

  // Data output register
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      d_out <= 8'h00;
    else if (rd_go)
      d_out <= (bcnt_q == 2'h0 || cd_sel) ? rword[7:0] : rword[15:8];
  end

  assign d_oe_n   = !(!cs_n && !rd_n);
  assign rdy_oe_n = !(strobe && wait_q != `RPM_RDY_WAIT);
  assign int_oe_n = !(|(chg_q & ien_q));

  // ****************************************************************
  // Packet report
  // ****************************************************************
  reg [1:0] rp_q;
  reg [7:0] fcs_q;
  localparam RP_IDLE = 2'h0;
  localparam RP_PORT = 2'h1;
  localparam RP_STAT = 2'h2;
  localparam RP_FCS  = 2'h3;

  // Trailer after each repeated packet
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rp_q      <= RP_IDLE;
      rep_valid <= 1'b0;
      rep_byte  <= 8'h00;
      fcs_q     <= 8'h00;
    end else begin
      rep_valid <= 1'b0;
      case (rp_q)
        RP_IDLE: if (pkt_end) begin
          rp_q      <= RP_PORT;
          rep_valid <= 1'b1;
          rep_byte  <= {4'h0, rx_port};
          fcs_q     <= {4'h0, rx_port};
        end
        RP_PORT: begin
          rp_q      <= RP_STAT;
          rep_valid <= 1'b1;
          rep_byte  <= {6'h00, jam_q, |part_q};
          fcs_q     <= fcs_q ^ {6'h00, jam_q, |part_q};
        end
        RP_STAT: begin
          rp_q      <= RP_FCS;
          rep_valid <= 1'b1;
          rep_byte  <= ~fcs_q;
        end
        RP_FCS:  rp_q <= RP_IDLE;
        default: rp_q <= RP_IDLE;
      endcase
    end
  end

endmodule // rpm_top

//--- testbench/rpm_top_properties.sv
/* Port checker for rpm_top: strobe handshake, bus drive, gating, limits.
   Assumes it is bound onto rpm_top and sees only its ports. */
`timescale 1ns/1ps
module rpm_checker (
  input wire        core_clk,  // Clock
  input wire        nrst,      // Reset, active low
  input wire [13:0] port_en,   // Port enables
  input wire [13:0] rx_act,    // Receive activity
  input wire [13:0] sqe,       // Collision presence
  input wire [13:0] tx_col,    // Transmit collision
  input wire        tx_act,    // Repeater transmitting
  input wire        pkt_end,   // End of packet
  input wire        cs_n,      // Chip select
  input wire        rd_n,      // Read strobe
  input wire        wr_n,      // Write strobe
  input wire [7:0]  d_out,     // Read data
  input wire        d_oe_n,    // Bus drive enable
  input wire        rdy_oe_n,  // Ready pull-low
  input wire        jam_out,   // Jam pad
  input wire [13:0] tx_en,     // Transmit enables
  input wire [13:0] rx_ok,     // Receive accepted
  input wire [13:0] part_q,    // Partition state
  input wire        rep_valid  // Report byte valid
);
  wire        stb = !cs_n && !(rd_n && wr_n);
  wire        rdg = !cs_n && !rd_n;
  reg  [9:0]  jam_q;
  reg  [7:0]  cause_q;
  reg  [7:0]  evt_q;
  reg  [13:0] rx_prev_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ****************************************************************
  // Helper counters
  // ****************************************************************
  // Jam run length, and ages of the last partition cause and packet end
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      jam_q <= 10'h000;
      cause_q <= 8'hFF;
      evt_q <= 8'hFF;
      rx_prev_q <= 14'h0000;
    end else begin
      jam_q <= jam_out ? jam_q + 10'h001 : 10'h000;
      rx_prev_q <= rx_act;
      if (|(sqe | tx_col)) cause_q <= 8'h00;
      else if (cause_q != 8'hFF) cause_q <= cause_q + 8'h01;
      if (pkt_end || $fell(tx_act) || |(rx_prev_q & ~rx_act))
        evt_q <= 8'h00;
      else if (evt_q != 8'hFF) evt_q <= evt_q + 8'h01;
    end
  end
  a_rdy_start: assert property (
    $rose(stb) |-> !rdy_oe_n ##[1:4] rdy_oe_n)
    else $error("ready not pulsed low then released");
  a_rdy_idle: assert property (!stb |-> rdy_oe_n)
    else $error("ready pulled low with no strobe");
  a_bus_drive: assert property (d_oe_n == (cs_n || rd_n))
    else $error("data bus drive does not follow chip read");
  a_dout_hold: assert property (
    rdg && $past(rdg) && $past(rdg, 2) |-> $stable(d_out))
    else $error("read data moved inside a strobe");
  a_tx_follow: assert property (tx_en == port_en)
    else $error("transmit enable differs from port enable");
  a_rx_gate: assert property (
    rx_ok == (port_en & rx_act & ~part_q))
    else $error("receive gating wrong");
  a_part_cause: assert property (
    |(part_q & ~$past(part_q)) |-> cause_q < 8'h10)
    else $error("partition with no collision cause");
  a_part_drop: assert property (
    |($past(part_q) & ~part_q) |-> evt_q < 8'h10)
    else $error("reconnect with no packet end");
  a_jam_len: assert property (jam_q <= 10'h184)
    else $error("jam pad longer than 97 bits");
  a_rep_after: assert property (pkt_end |-> ##[1:64] rep_valid)
    else $error("no report after packet");
  c_part: cover property ($rose(|part_q));
  c_recon: cover property ($fell(|part_q));
  c_jam: cover property ($rose(jam_out));
endmodule // rpm_checker

bind rpm_top rpm_checker u_chk (
  .core_clk(core_clk), .nrst(nrst), .port_en(port_en), .rx_act(rx_act),
  .sqe(sqe), .tx_col(tx_col), .tx_act(tx_act), .pkt_end(pkt_end),
  .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .d_out(d_out), .d_oe_n(d_oe_n),
  .rdy_oe_n(rdy_oe_n), .jam_out(jam_out), .tx_en(tx_en), .rx_ok(rx_ok),
  .part_q(part_q), .rep_valid(rep_valid));

//--- testbench/rpm_cpu_model.sv
/* Processor model on the management port of rpm_top.
   Assumes the bench wires its pins to rpm_top; ready has a pull-up. */
`timescale 1ns/1ps
module rpm_cpu_model (
  input  wire       core_clk,  // Clock
  input  wire       rdy_oe_n,  // Ready pull-low enable
  output reg        cs_n,      // Chip select
  output reg        rd_n,      // Read strobe
  output reg        wr_n,      // Write strobe
  output reg        cd_sel,    // Control/data select
  output reg  [7:0] d_in,      // Write data
  output reg        hung       // Ready never came
);
  integer n;
  reg     rdy_s;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    cd_sel = 1'b0;
    d_in = 8'h00;
    hung = 1'b0;
  end
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Ready level sampled where settled, ahead of each rising edge
  always @(negedge core_clk) rdy_s <= rdy_oe_n;
  // One strobe, held until ready is seen high at a rising edge
  task cyc(input c, input r, input [7:0] v);
    begin
      @(posedge core_clk);
      cs_n <= 1'b0;
      cd_sel <= c;
      rd_n <= !r;
      wr_n <= r;
      d_in <= v;
      n = 0;
      @(posedge core_clk);
      while (!rdy_s && n < 32) begin
        @(posedge core_clk);
        n = n + 1;
      end
      if (n == 32) hung <= 1'b1;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      d_in <= ~v;                        // Released bus keeps no stale value
    end
  endtask
  // Bank then register select; only documented banks are named
  task sel(input [4:0] b, input [4:0] r);
    begin
      cyc(1'b1, 1'b0, {3'h0, b});
      cyc(1'b1, 1'b0, {3'h7, r});
    end
  endtask
  // Two-byte write, low byte first
  task wr16(input [15:0] v);
    begin
      cyc(1'b0, 1'b0, v[7:0]);
      cyc(1'b0, 1'b0, v[15:8]);
    end
  endtask
endmodule // rpm_cpu_model

//--- testbench/tb_rpm_top.sv
/* Self-checking bench for rpm_top: partition, reconnect, registers.
   Assumes rpm_cpu_model and the bound checker are compiled with it. */
`timescale 1ns/1ps
module tb_rpm_top;
  reg         core_clk, nrst, tx_act, pkt_end, took, jam_hit;
  reg  [13:0] port_en, rx_act, sqe, tx_col;
  reg  [3:0]  rx_port;
  wire        cs_n, rd_n, wr_n, cd_sel, hung, d_oe_n, rdy_oe_n;
  wire        int_oe_n, jam_out, rep_valid;
  wire [7:0]  d_in, d_out, rep_byte;
  wire [13:0] tx_en, rx_ok, part_q;
  integer     fail_count, tests_run, seed, idx, rnd;
  reg  [7:0]  exp_q[$];
  reg  [7:0]  rep_q[$];
  reg  [7:0]  racc;
  rpm_top dut (.core_clk(core_clk), .nrst(nrst), .port_en(port_en),
    .rx_act(rx_act), .sqe(sqe), .tx_col(tx_col), .tx_act(tx_act),
    .rx_port(rx_port), .pkt_end(pkt_end), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .cd_sel(cd_sel), .d_in(d_in), .d_out(d_out),
    .d_oe_n(d_oe_n), .rdy_oe_n(rdy_oe_n), .int_oe_n(int_oe_n),
    .jam_out(jam_out), .tx_en(tx_en), .rx_ok(rx_ok), .part_q(part_q),
    .rep_valid(rep_valid), .rep_byte(rep_byte));
  rpm_cpu_model u_cpu (.core_clk(core_clk), .rdy_oe_n(rdy_oe_n),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .cd_sel(cd_sel), .d_in(d_in),
    .hung(hung));
  // ****************************************************************
  // Clock, compare and report
  // ****************************************************************
  always #12.5 core_clk = ~core_clk;
  task check(input [63:0] nm, input [15:0] seen, input [15:0] want);
    begin
      tests_run = tests_run + 1;
      if (seen !== want) begin
        fail_count = fail_count + 1;
        $display("BAD %s expected %h seen %h", nm, want, seen);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  // A hung handshake ends the run
  always @(posedge hung) begin
    fail_count = fail_count + 1;
    report_and_stop;
  end
  // Read values and report headers taken off the queues as they appear
  always @(negedge core_clk) begin
    if (jam_out) jam_hit = 1'b1;
    if (d_oe_n) took = 1'b0;
    else if (rdy_oe_n && !took) begin
      took = 1'b1;
      if (exp_q.size() == 0)
        check("rd_extra", 16'h0001, 16'h0000);
      else
        check("rd_data", d_out, exp_q.pop_front());
    end
    // Report: port byte from the queue, last byte inverts the running xor
    if (rep_valid) begin
      if (idx == 0 && rep_q.size() == 0)
        check("rep_xtra", 1, 0);
      else if (idx == 0)
        check("rep_port", rep_byte, rep_q.pop_front());
      if (idx == 2)
        check("rep_fcs", rep_byte, {8'h00, ~racc});
      racc = (idx == 0) ? rep_byte : racc ^ rep_byte;
      idx = (idx + 1) % 3;
    end
  end
  // ****************************************************************
  // Stimulus
  // ****************************************************************
  task rd8(input c, input [7:0] e);
    begin
      exp_q.push_back(e);
      u_cpu.cyc(c, 1'b1, 8'h00);
    end
  endtask
  task rd16(input [15:0] e);
    begin
      rd8(1'b0, e[7:0]);
      rd8(1'b0, e[15:8]);
    end
  endtask
  task chkp(input [13:0] e);
    begin
      #1 check("part_q", part_q, e);
    end
  endtask
  // One packet of nb bit times, transmitted or received on port p
  task pkt(input tx, input [3:0] p, input [11:0] nb);
    begin
      @(posedge core_clk);
      rx_port <= p;
      tx_act <= tx;
      if (!tx) rx_act[p] <= 1'b1;
      repeat (nb * 4) @(posedge core_clk);
      pkt_end <= 1'b1;
      rep_q.push_back({4'h0, p});
      @(posedge core_clk);
      pkt_end <= 1'b0;
      tx_act <= 1'b0;
      rx_act <= 14'h0000;
      repeat (16) @(posedge core_clk);
    end
  endtask
  // Transmit attempts to port 2 that all collide
  task col(input integer k);
    begin
      repeat (k) begin
        @(posedge core_clk);
        tx_act <= 1'b1;
        tx_col[2] <= 1'b1;
        repeat (8) @(posedge core_clk);
        tx_act <= 1'b0;
        tx_col[2] <= 1'b0;
        repeat (400) @(posedge core_clk);
      end
    end
  endtask
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    port_en = 14'h3FFF;
    {rx_act, sqe, tx_col} = 42'h0;
    {tx_act, pkt_end, took, jam_hit} = 4'h0;
    rx_port = 4'h0;
    fail_count = 0;
    tests_run = 0;
    idx = 0;
    seed = 20;
    rnd = $random(seed);
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd8(1'b1, 8'h00);
    u_cpu.sel(5'h04, 5'h00);
    rd16(16'h0000);
    sqe[2] <= 1'b1;
    repeat (8100) @(posedge core_clk);
    chkp(14'h0000);
    repeat (150) @(posedge core_clk);
    chkp(14'h0004);
    @(posedge core_clk);
    sqe <= 14'h0000;
    u_cpu.sel(5'h04, 5'h00);
    rd16(16'h0004);
    u_cpu.sel(5'h02, 5'h00);
    u_cpu.wr16(16'h0004);
    rd8(1'b1, 8'h01);
    #1 check("int_oe_n", int_oe_n, 1'b0);
    u_cpu.sel(5'h01, 5'h00);
    u_cpu.wr16(16'h0004);
    rd8(1'b1, 8'h00);
    #1 check("int_oe_n", int_oe_n, 1'b1);
    pkt(1'b0, 4'h2, 12'h208);
    chkp(14'h0000);
    u_cpu.sel(5'h03, 5'h00);
    u_cpu.wr16(16'h0004);
    u_cpu.sel(5'h03, 5'h00);
    u_cpu.cyc(1'b0, 1'b0, rnd[7:0]);
    u_cpu.sel(5'h03, 5'h00);
    rd16(16'h0004);
    col(31);
    chkp(14'h0000);
    col(1);
    chkp(14'h0004);
    pkt(1'b0, 4'h2, 12'h208);
    chkp(14'h0004);
    jam_hit = 1'b0;
    pkt(1'b1, {1'b0, rnd[10:8]}, 12'h208);
    chkp(14'h0000);
    check("jam_long", jam_hit, 1'b0);
    pkt(1'b1, 4'h5, 12'h014);
    check("jam_frag", jam_hit, 1'b1);
    repeat (400) @(posedge core_clk);
    check("rd_left", exp_q.size(), 0);
    check("rep_left", rep_q.size(), 0);
    report_and_stop;
  end
endmodule // tb_rpm_top
